// >>> rtl/asc_pkg.sv
// Constants for the converter sequencer control block
// Operation
// - A conversion lasts nine and a half bit periods from start to done.
// - Bit period is 2, 8 or 32 oscillator periods or the RC clock.
// - Conversion continues in sleep when the RC clock is selected.
// - RC bit period is typically four microseconds.
// - Hold capacitor disconnects from the pin when conversion starts.
// - The selected pin level is converted whatever its direction.
// - Port read returns zero for analog configured pins.
// - Special event trigger with converter on sets go and starts.
// - Each special event trigger clears the sixteen bit timer.
// - Converter off ignores triggers, timer still clears.
// - Result survives resets; control registers clear on every reset.
// - Completion loads result, clears go and sets done flag.
// - Channel select codes 000 to 100 pick channels zero to four.
// - Clock code 11 picks RC; 00, 01, 10 pick 2, 8, 32 periods.
// - Reset turns the converter off and aborts a conversion.
package asc_pkg;
    // ==========================================================
    // Register indices and byte addresses
    localparam logic [7:0]  IDX_PORT_PINS    = 8'h05;
    localparam logic [7:0]  IDX_INT_CTRL     = 8'h0B;
    localparam logic [7:0]  IDX_PERIPH_FLAGS = 8'h0C;
    localparam logic [7:0]  IDX_RESULT       = 8'h1E;
    localparam logic [7:0]  IDX_CONV_CTRL    = 8'h1F;
    localparam logic [7:0]  IDX_PORT_DIR     = 8'h85;
    localparam logic [7:0]  IDX_PERIPH_EN    = 8'h8C;
    localparam logic [7:0]  IDX_PIN_SETUP    = 8'h9F;
    localparam int          ADDR_W           = 12;
    localparam logic [11:0] ADDR_PORT_PINS    = {2'h0, IDX_PORT_PINS, 2'h0};
    localparam logic [11:0] ADDR_INT_CTRL     = {2'h0, IDX_INT_CTRL, 2'h0};
    localparam logic [11:0] ADDR_PERIPH_FLAGS = {2'h0, IDX_PERIPH_FLAGS, 2'h0};
    localparam logic [11:0] ADDR_RESULT       = {2'h0, IDX_RESULT, 2'h0};
    localparam logic [11:0] ADDR_CONV_CTRL    = {2'h0, IDX_CONV_CTRL, 2'h0};
    localparam logic [11:0] ADDR_PORT_DIR     = {2'h0, IDX_PORT_DIR, 2'h0};
    localparam logic [11:0] ADDR_PERIPH_EN    = {2'h0, IDX_PERIPH_EN, 2'h0};
    localparam logic [11:0] ADDR_PIN_SETUP    = {2'h0, IDX_PIN_SETUP, 2'h0};
    // ==========================================================
    // Field positions
    localparam int CTRL_ON_BIT   = 0;
    localparam int CTRL_GO_BIT   = 2;
    localparam int CTRL_CHS_LSB  = 3;
    localparam int CTRL_CLK_LSB  = 6;
    localparam int FLAG_DONE_BIT = 6;
    localparam int SETUP_CFG_W   = 3;
    localparam int PORT_W        = 6;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_CONV_CTRL    = 8'h00;
    localparam logic [7:0] RST_PIN_SETUP    = 8'h00;
    localparam logic [7:0] RST_PERIPH_FLAGS = 8'h00;
    localparam logic [7:0] RST_PERIPH_EN    = 8'h00;
    localparam logic [7:0] RST_INT_CTRL     = 8'h00;
    localparam logic [7:0] RST_PORT_DIR     = 8'h3F;
    localparam logic [7:0] RST_PORT_PINS    = 8'h00;
    // ==========================================================
    // Modes and timing
    localparam logic [1:0] CLK_OSC2   = 2'h0;
    localparam logic [1:0] CLK_OSC8   = 2'h1;
    localparam logic [1:0] CLK_OSC32  = 2'h2;
    localparam logic [1:0] CLK_RC     = 2'h3;
    localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RC_TAD_NS     = 4000;
    localparam int RC_HALF_CYC   = (RC_TAD_NS / 2) / CLK_PERIOD_NS;
    localparam logic [7:0] HALF_OSC2  = 8'h01;
    localparam logic [7:0] HALF_OSC8  = 8'h04;
    localparam logic [7:0] HALF_OSC32 = 8'h10;
    localparam logic [7:0] HALF_RC    = 8'(RC_HALF_CYC);
    localparam logic [4:0] HALF_TADS  = 5'h13;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } asc_state_t;
endpackage

// >>> rtl/asc_sequencer.sv
// Converter sequencer control with APB registers and port pin logic
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module asc_sequencer import asc_pkg::*; #(
    parameter int CHANNELS = 5
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Core state and compare unit
    input  wire logic                  coreSleep,
    input  wire logic                  compareEvent,
    input  wire logic [3:0]            compareMode,
    output logic                       timerClear,
    // Port pins and analog levels
    input  wire logic [PORT_W-1:0]     padIn,
    output logic      [PORT_W-1:0]     padOut,
    output logic      [PORT_W-1:0]     padOe,
    input  wire logic [CHANNELS*8-1:0] analogLevel,
    output logic                       holdConnected
);
    // ==========================================================
    // Decoding helpers
    function automatic logic [PORT_W-1:0] analogMask(input logic [2:0] c);
        if (c[2:1] == 2'h3) begin
            analogMask = 6'h00;
        end else if (c[2]) begin
            analogMask = 6'h0B;
        end else begin
            analogMask = 6'h2F;
        end
    endfunction

    function automatic logic [7:0] halfLimit(input logic [1:0] s);
        if (s == CLK_OSC2) begin
            halfLimit = HALF_OSC2;
        end else if (s == CLK_OSC8) begin
            halfLimit = HALF_OSC8;
        end else if (s == CLK_OSC32) begin
            halfLimit = HALF_OSC32;
        end else begin
            halfLimit = HALF_RC;
        end
    endfunction

    // ==========================================================
    // Input synchronisers
    logic [CHANNELS*8-1:0] anaMeta_reg;
    logic [CHANNELS*8-1:0] anaSync_reg;
    logic [PORT_W-1:0]     padMeta_reg;
    logic [PORT_W-1:0]     padSync_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            anaMeta_reg <= '0;
            anaSync_reg <= '0;
            padMeta_reg <= '0;
            padSync_reg <= '0;
        end else begin
            anaMeta_reg <= analogLevel;
            anaSync_reg <= anaMeta_reg;
            padMeta_reg <= padIn;
            padSync_reg <= padMeta_reg;
        end
    end

    // ==========================================================
    // Registers
    logic             convOn_reg;
    logic             go_reg;
    logic [2:0]       chanSel_reg;
    logic [1:0]       clkSel_reg;
    logic [2:0]       pinCfg_reg;
    logic             doneFlag_reg;
    logic [7:0]       otherFlags_reg;
    logic [7:0]       periphEn_reg;
    logic [7:0]       intCtrl_reg;
    logic [5:0]       portDir_reg;
    logic [5:0]       portLatch_reg;
    logic [7:0]       result_reg;
    logic [7:0]       held_reg;
    logic [31:0]      prdata_reg;
    logic             slvErr_reg;
    logic             timerClear_reg;
    asc_state_t       state_reg;
    logic [7:0]       divCnt_reg;
    logic [4:0]       halfCnt_reg;

    // ==========================================================
    // Bus decode
    wire setupPhase = psel & ~penable;
    wire accessWr   = psel & penable & pwrite;
    wire hitPins    = (paddr == ADDR_PORT_PINS);
    wire hitInt     = (paddr == ADDR_INT_CTRL);
    wire hitFlags   = (paddr == ADDR_PERIPH_FLAGS);
    wire hitResult  = (paddr == ADDR_RESULT);
    wire hitCtrl    = (paddr == ADDR_CONV_CTRL);
    wire hitDir     = (paddr == ADDR_PORT_DIR);
    wire hitEn      = (paddr == ADDR_PERIPH_EN);
    wire hitSetup   = (paddr == ADDR_PIN_SETUP);
    wire hitAny     = hitPins | hitInt | hitFlags | hitResult | hitCtrl
                    | hitDir | hitEn | hitSetup;
    wire ctrlWr     = accessWr & hitCtrl;
    wire flagsWr    = accessWr & hitFlags;

    wire [PORT_W-1:0] anaMask   = analogMask(pinCfg_reg);
    wire [PORT_W-1:0] portRead  = padSync_reg & ~anaMask;
    wire [7:0]        ctrlRead  = {clkSel_reg, chanSel_reg, go_reg,
                                   1'b0, convOn_reg};
    wire [7:0]        flagsRead = {otherFlags_reg[7], doneFlag_reg,
                                   otherFlags_reg[5:0]};
    logic [7:0] readByte;
    always_comb begin
        if (hitPins) begin
            readByte = {2'h0, portRead};
        end else if (hitInt) begin
            readByte = intCtrl_reg;
        end else if (hitFlags) begin
            readByte = flagsRead;
        end else if (hitResult) begin
            readByte = result_reg;
        end else if (hitCtrl) begin
            readByte = ctrlRead;
        end else if (hitDir) begin
            readByte = {2'h0, portDir_reg};
        end else if (hitEn) begin
            readByte = periphEn_reg;
        end else if (hitSetup) begin
            readByte = {5'h00, pinCfg_reg};
        end else begin
            readByte = 8'h00;
        end
    end

    // ==========================================================
    // Start, trigger and completion
    wire specialEvt = compareEvent & (compareMode == MODE_SPECIAL_EVENT);
    wire trigger    = specialEvt & convOn_reg;
    wire onNext     = ctrlWr ? pwdata[CTRL_ON_BIT] : convOn_reg;
    wire goWrite    = ctrlWr ? (pwdata[CTRL_GO_BIT] & convOn_reg
                                & pwdata[CTRL_ON_BIT]) : go_reg;
    wire inConv     = (state_reg == ST_CONV);
    wire oscStopped = coreSleep & (clkSel_reg != CLK_RC);
    wire [7:0] limit = halfLimit(clkSel_reg);
    wire tadTick    = inConv & ~oscStopped & (divCnt_reg == limit - 8'h01);
    wire convDone   = tadTick & go_reg
                    & (halfCnt_reg == HALF_TADS - 5'h01);
    wire goNext     = (trigger & onNext) | (~trigger & ~convDone & goWrite);
    wire startConv  = (state_reg == ST_IDLE) & go_reg;
    wire abortConv  = inConv & ~go_reg;

    // Channel map and sampled level, driven pins give their own level
    logic [7:0] chanLevel;
    logic [2:0] chanPin;
    always_comb begin
        chanLevel = 8'h00;
        chanPin   = 3'h0;
        if (chanSel_reg < 3'(CHANNELS)) begin
            chanPin   = (chanSel_reg == 3'h4) ? 3'h5 : chanSel_reg;
            chanLevel = anaSync_reg[chanSel_reg*8 +: 8];
            if (!portDir_reg[chanPin]) begin
                chanLevel = portLatch_reg[chanPin] ? 8'hFF : 8'h00;
            end
        end
    end

    // ==========================================================
    // Control and configuration registers, cleared on every reset except port direction, which loads 3F
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            convOn_reg  <= RST_CONV_CTRL[CTRL_ON_BIT];
            go_reg      <= RST_CONV_CTRL[CTRL_GO_BIT];
            chanSel_reg <= RST_CONV_CTRL[CTRL_CHS_LSB +: 3];
            clkSel_reg  <= RST_CONV_CTRL[CTRL_CLK_LSB +: 2];
            pinCfg_reg  <= RST_PIN_SETUP[SETUP_CFG_W-1:0];
            periphEn_reg   <= RST_PERIPH_EN;
            intCtrl_reg    <= RST_INT_CTRL;
            portDir_reg    <= RST_PORT_DIR[PORT_W-1:0];
            portLatch_reg  <= RST_PORT_PINS[PORT_W-1:0];
            otherFlags_reg <= RST_PERIPH_FLAGS;
        end else begin
            convOn_reg <= onNext;
            go_reg     <= goNext;
            if (ctrlWr) begin
                chanSel_reg <= pwdata[CTRL_CHS_LSB +: 3];
                clkSel_reg  <= pwdata[CTRL_CLK_LSB +: 2];
            end
            if (accessWr & hitSetup) pinCfg_reg <= pwdata[2:0];
            if (accessWr & hitEn)    periphEn_reg <= pwdata[7:0];
            if (accessWr & hitInt)   intCtrl_reg <= pwdata[7:0];
            if (accessWr & hitDir)   portDir_reg <= pwdata[5:0];
            if (accessWr & hitPins)  portLatch_reg <= pwdata[5:0];
            if (flagsWr)             otherFlags_reg <= pwdata[7:0];
        end
    end

    // Done flag: hardware set wins over a software clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            doneFlag_reg <= RST_PERIPH_FLAGS[FLAG_DONE_BIT];
        end else if (convDone) begin
            doneFlag_reg <= 1'b1;
        end else if (flagsWr) begin
            doneFlag_reg <= pwdata[FLAG_DONE_BIT];
        end
    end

    // Result keeps its value through every reset
    always_ff @(posedge core_clk) begin
        if (convDone) result_reg <= held_reg;
        if (startConv) held_reg <= chanLevel;
    end

    // ==========================================================
    // Conversion timing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg   <= ST_IDLE;
            divCnt_reg  <= 8'h00;
            halfCnt_reg <= 5'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    divCnt_reg  <= 8'h00;
                    halfCnt_reg <= 5'h00;
                    if (startConv) state_reg <= ST_CONV;
                end
                ST_CONV: begin
                    if (abortConv || convDone) begin
                        state_reg <= ST_IDLE;
                    end else if (tadTick) begin
                        divCnt_reg  <= 8'h00;
                        halfCnt_reg <= halfCnt_reg + 5'h01;
                    end else if (!oscStopped) begin
                        divCnt_reg <= divCnt_reg + 8'h01;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Bus answer and outputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata_reg     <= 32'h0000_0000;
            slvErr_reg     <= 1'b0;
            timerClear_reg <= 1'b0;
        end else begin
            if (setupPhase) begin
                prdata_reg <= {24'h00_0000, readByte};
                slvErr_reg <= ~hitAny;
            end
            timerClear_reg <= specialEvt;
        end
    end

    assign prdata        = prdata_reg;
    assign pready        = psel & penable;
    assign pslverr       = psel & penable & slvErr_reg;
    assign timerClear    = timerClear_reg;
    assign padOut        = portLatch_reg;
    assign padOe         = ~portDir_reg;
    assign holdConnected = ~inConv;

    // ==========================================================
    // Checks
    logic [7:0] convLen_reg;
    logic       irregular_reg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            convLen_reg   <= 8'h00;
            irregular_reg <= 1'b0;
        end else if (startConv) begin
            convLen_reg   <= 8'h00;
            irregular_reg <= 1'b0;
        end else if (inConv) begin
            convLen_reg   <= convLen_reg + 8'h01;
            if (coreSleep || clkSel_reg != CLK_OSC2) irregular_reg <= 1'b1;
        end
    end

    a_fast_conv_len: assert property (@(posedge core_clk) disable iff (rst)
        convDone && !irregular_reg && !coreSleep && clkSel_reg == CLK_OSC2
        |-> convLen_reg == 8'h12)
        else $error("conversion length wrong at fastest clock");
    a_rc_tick_gap: assert property (@(posedge core_clk) disable iff (rst)
        tadTick && clkSel_reg == CLK_RC ##1 clkSel_reg == CLK_RC
        |-> !tadTick [*8])
        else $error("RC half period too short");
    a_done_load: assert property (@(posedge core_clk) disable iff (rst)
        convDone |=> !go_reg && doneFlag_reg
        && result_reg == $past(held_reg) && state_reg == ST_IDLE)
        else $error("completion effects missing");
    a_hold_open: assert property (@(posedge core_clk) disable iff (rst)
        startConv |=> !holdConnected && held_reg == $past(chanLevel))
        else $error("hold not released at start");
    a_trig_start: assert property (@(posedge core_clk) disable iff (rst)
        trigger && !ctrlWr |=> go_reg ##1 inConv)
        else $error("trigger did not start conversion");
    a_trig_timer: assert property (@(posedge core_clk) disable iff (rst)
        specialEvt |=> timerClear)
        else $error("trigger did not clear timer");
    a_off_ignore: assert property (@(posedge core_clk) disable iff (rst)
        specialEvt && !convOn_reg && !go_reg |=> !go_reg && timerClear)
        else $error("trigger acted while off");
    a_abort_quiet: assert property (@(posedge core_clk) disable iff (rst)
        abortConv |=> state_reg == ST_IDLE && $stable(result_reg)
        && doneFlag_reg == ($past(flagsWr) ? $past(pwdata[FLAG_DONE_BIT])
                            : $past(doneFlag_reg)))
        else $error("abort changed result");
    a_port_zero: assert property (@(posedge core_clk) disable iff (rst)
        setupPhase && hitPins && $stable(pinCfg_reg)
        |=> (prdata[5:0] & anaMask) == 6'h00)
        else $error("analog pin read not zero");
    a_sleep_hold: assert property (@(posedge core_clk) disable iff (rst)
        inConv && oscStopped && go_reg |=> $stable(halfCnt_reg))
        else $error("conversion ran with oscillator stopped");

    c_soft_done: cover property (@(posedge core_clk) disable iff (rst)
        ctrlWr && pwdata[CTRL_GO_BIT] ##[1:1000] convDone);
    c_trig_done: cover property (@(posedge core_clk) disable iff (rst)
        trigger ##[1:1000] convDone);
    c_abort: cover property (@(posedge core_clk) disable iff (rst)
        abortConv);
    c_rc_done: cover property (@(posedge core_clk) disable iff (rst)
        convDone && clkSel_reg == CLK_RC);
endmodule

// >>> test/adc_sequencer_control_test.sv
// Self-checking bench for the converter sequencer control block
`timescale 1ns/1ps
module adc_sequencer_control_test import asc_pkg::*;;
    logic                  core_clk, rst, psel, penable, pwrite;
    logic                  coreSleep, compareEvent, slvErr;
    logic                  pready, pslverr, timerClear, holdConnected;
    logic [ADDR_W-1:0]     paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic [3:0]            compareMode;
    logic [PORT_W-1:0]     padIn, padOut, padOe;
    logic [39:0]           analogLevel, srcLevel;
    int                    errors, nCompared;
    localparam logic [11:0] RA [6] = '{ADDR_CONV_CTRL, ADDR_PIN_SETUP,
        ADDR_PERIPH_FLAGS, ADDR_PERIPH_EN, ADDR_INT_CTRL, ADDR_PORT_DIR};
    localparam logic [7:0]  RV [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h3F};
    localparam int          CYC [4] = '{19, 76, 304, 1520};
    localparam logic [7:0]  PC [3] = '{8'h00, 8'h04, 8'h06};
    localparam logic [7:0]  PR [3] = '{8'h10, 8'h34, 8'h3F};

    asc_sequencer #(.CHANNELS(5)) dut (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .coreSleep(coreSleep),
        .compareEvent(compareEvent), .compareMode(compareMode),
        .timerClear(timerClear), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .analogLevel(analogLevel),
        .holdConnected(holdConnected));
    asc_pin_model pins (.padOut(padOut), .padOe(padOe),
        .srcLevel(srcLevel), .padIn(padIn), .analogLevel(analogLevel));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // =====================================================
    // Checking and closing
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        nCompared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // =====================================================
    // APB transfer, held until pready is sampled high
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            end_of_test();
        end
        rd = prdata;
        slvErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // Counts the cycles the hold capacitor stays off the pin
    task automatic measure(input int cyc);
        int n;
        n = 0;
        @(negedge core_clk);
        while (holdConnected !== 1'b0 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        while (holdConnected === 1'b0 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        chk("conversion cycles", 32'(n), 32'(cyc));
        @(posedge core_clk);
    endtask
    task automatic result(input logic [7:0] ctl, input logic [7:0] res);
        bus(1'b0, ADDR_RESULT, 8'h00);
        chk("result", rd, {24'h0, res});
        bus(1'b0, ADDR_CONV_CTRL, 8'h00);
        chk("go cleared", rd, {24'h0, ctl & 8'hFB});
        bus(1'b0, ADDR_PERIPH_FLAGS, 8'h00);
        chk("done flag", rd, 32'h40);
    endtask
    task automatic convert(input logic [7:0] ctl, input int cyc,
                           input logic [7:0] res);
        bus(1'b1, ADDR_PERIPH_FLAGS, 8'h00);
        bus(1'b1, ADDR_CONV_CTRL, ctl & 8'hFB);
        repeat (4) @(posedge core_clk);
        bus(1'b1, ADDR_CONV_CTRL, ctl);
        measure(cyc);
        result(ctl, res);
    endtask
    task automatic trig;
        compareEvent <= 1'b1;
        @(posedge core_clk);
        compareEvent <= 1'b0;
        @(negedge core_clk);
        chk("timer clear", {31'h0, timerClear}, 32'h1);
        @(posedge core_clk);
    endtask
    // =====================================================
    // Main sequence
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; coreSleep = 1'b0; compareEvent = 1'b0;
        compareMode = 4'h0; srcLevel = 40'h9C7B5A3918;
        errors = 0; nCompared = 0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, RA[i], 8'h00);
            chk("reset value", rd, {24'h0, RV[i]});
        end
        bus(1'b0, 12'h000, 8'h00);
        chk("unmapped error", {31'h0, slvErr}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        bus(1'b1, ADDR_CONV_CTRL, 8'h05);
        bus(1'b0, ADDR_CONV_CTRL, 8'h00);
        chk("go with enable", rd, 32'h01);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            coreSleep <= (i == 3);
            convert({2'(i % 4), 3'(i), 3'b101}, CYC[i % 4],
                    srcLevel[8*i+:8]);
        end
        coreSleep <= 1'b0;
        bus(1'b1, ADDR_PORT_PINS, 8'h01);
        bus(1'b1, ADDR_PORT_DIR, 8'h3E);
        chk("pad drive", {20'h0, padOe, padOut}, 32'h0000_0041);
        convert(8'h05, 19, 8'hFF);
        bus(1'b1, ADDR_PORT_DIR, 8'h3F);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, ADDR_PIN_SETUP, PC[i]);
            bus(1'b0, ADDR_PORT_PINS, 8'h00);
            chk("port read", rd, {24'h0, PR[i]});
        end
        convert(8'h0D, 19, srcLevel[15:8]);
        $display("test conversions done");
        compareMode <= MODE_SPECIAL_EVENT;
        bus(1'b1, ADDR_CONV_CTRL, 8'h00);
        trig();
        bus(1'b0, ADDR_CONV_CTRL, 8'h00);
        chk("trigger while off", rd, 32'h0);
        bus(1'b1, ADDR_PERIPH_FLAGS, 8'h00);
        bus(1'b1, ADDR_CONV_CTRL, 8'h01);
        repeat (4) @(posedge core_clk);
        trig();
        measure(19);
        result(8'h01, srcLevel[7:0]);
        coreSleep <= 1'b1;
        bus(1'b1, ADDR_PERIPH_FLAGS, 8'h00);
        bus(1'b1, ADDR_CONV_CTRL, 8'h05);
        repeat (30) @(posedge core_clk);
        chk("hold in sleep", {31'h0, holdConnected}, 32'h0);
        coreSleep <= 1'b0;
        measure(19);
        result(8'h05, srcLevel[7:0]);
        $display("test trigger done");
        bus(1'b1, ADDR_PERIPH_FLAGS, 8'h00);
        bus(1'b1, ADDR_CONV_CTRL, 8'h81);
        bus(1'b1, ADDR_CONV_CTRL, 8'h85);
        repeat (10) @(posedge core_clk);
        bus(1'b1, ADDR_CONV_CTRL, 8'h81);
        @(negedge core_clk);
        chk("hold after abort", {31'h0, holdConnected}, 32'h1);
        repeat (400) @(posedge core_clk);
        bus(1'b0, ADDR_PERIPH_FLAGS, 8'h00);
        chk("flag after abort", rd, 32'h0);
        bus(1'b1, ADDR_CONV_CTRL, 8'h85);
        repeat (10) @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("hold after reset", {31'h0, holdConnected}, 32'h1);
        bus(1'b0, ADDR_CONV_CTRL, 8'h00);
        chk("control after reset", rd, 32'h0);
        bus(1'b0, ADDR_RESULT, 8'h00);
        chk("result kept", rd, {24'h0, srcLevel[7:0]});
        $display("test aborts done");
        end_of_test();
    end
endmodule

// >>> test/asc_pin_model.sv
// Pin and analog source model on the far side of the converter block
`timescale 1ns/1ps
module asc_pin_model import asc_pkg::*; (
    // Levels the block drives on the port
    input  wire logic [PORT_W-1:0] padOut,
    input  wire logic [PORT_W-1:0] padOe,
    // Source levels of the five analog channels
    input  wire logic [39:0]       srcLevel,
    // Levels seen by the block
    output logic      [PORT_W-1:0] padIn,
    output logic      [39:0]       analogLevel
);
    // =====================================================
    // Undriven pins are pulled up
    for (genvar i = 0; i < PORT_W; i++) begin : g_pad
        assign padIn[i] = padOe[i] ? padOut[i] : 1'b1;
    end
    // =====================================================
    // Channel four sits on the sixth pin; a driven pin shows its own level
    for (genvar k = 0; k < 5; k++) begin : g_chan
        localparam int P = (k == 4) ? 5 : k;
        assign analogLevel[8*k+:8] = padOe[P] ? {8{padOut[P]}}
                                              : srcLevel[8*k+:8];
    end
endmodule
